// *** logic/pts_timer.sv ***
// Purpose: 16-bit periodic timer, single-pulse output and capture input modes
// Assumes: Byte register port; timer ticks come from a divider of mclk_i
// Notes:   Other timer modes hold the counter idle
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pts_timer
   import pts_pkg::*;
#(
   parameter int TICK_DIV = PTS_TICK_DIV
) (
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   input  wire logic       ext_timer_clock_pin_i,
   input  wire logic       capture_input_pin_i,
   output logic [7:0]      rdata_o,
   output logic            timer_out_o,
   output logic            timer_out_en_o,
   output logic            compare_a_flag_o,
   output logic            compare_p_flag_o
);
   ////////////////////////////////////////////////////////////////////////////
   logic [1:0]           timer_mode_sel;
   logic [1:0]           pin_function;
   logic                 output_initial_state;
   logic                 output_polarity;
   logic                 capture_source_select;
   logic                 counter_clear_select;
   logic                 run_bit;
   logic                 run_q;
   logic [PTS_CNT_W-1:0] counter;
   logic [PTS_CNT_W-1:0] compare_a_value;
   logic [PTS_CNT_W-1:0] compare_p_value;
   logic [7:0]           a_hi_buf;
   logic [7:0]           p_hi_buf;
   logic [7:0]           next_rdata;
   logic                 cap_pend;
   logic                 af_pend;
   logic [15:0]          div_cnt;
   logic                 tick;
   logic                 trg_rise;
   logic                 trg_fall;
   logic                 cpi_rise;
   logic                 cpi_fall;
   logic                 src_rise;
   logic                 src_fall;
   logic                 cap_edge;
   logic                 trg_edge;
   logic                 sp_mode;
   logic                 cap_mode;
   logic                 run_rise;
   logic                 a_match;
   logic                 p_match;
   logic                 out_lvl;
   pts_state_e           state;
   pts_state_e           next_state;

   function automatic logic edge_sel(input logic [1:0] pf, input logic r, input logic f);
      case (pf)
         PTS_PINF_RISE: edge_sel = r;
         PTS_PINF_FALL: edge_sel = f;
         PTS_PINF_BOTH: edge_sel = r | f;
         default:       edge_sel = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   pts_edge_sync u_trg (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .pin_i    (ext_timer_clock_pin_i),
      .rise_o   (trg_rise),
      .fall_o   (trg_fall)
   );
   pts_edge_sync u_cpi (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .pin_i    (capture_input_pin_i),
      .rise_o   (cpi_rise),
      .fall_o   (cpi_fall)
   );

   assign sp_mode  = (timer_mode_sel == PTS_MODE_SP);
   assign cap_mode = (timer_mode_sel == PTS_MODE_CAP);
   assign src_rise = capture_source_select ? trg_rise : cpi_rise;
   assign src_fall = capture_source_select ? trg_fall : cpi_fall;
   // Both-bits-high decodes to no edge, counter unaffected
   assign cap_edge = cap_mode && run_bit && edge_sel(pin_function, src_rise, src_fall);
   // Trigger pin active edge is always the rising edge; pin function is not used
   assign trg_edge = sp_mode && !run_bit && trg_rise;
   assign run_rise = run_bit && !run_q;
   assign a_match  = tick && (state == PTS_ST_RUN) && sp_mode && (counter == compare_a_value);
   // Zero compare P never matches, so the counter wraps at full range
   assign p_match  = tick && (state == PTS_ST_CAP) && (compare_p_value != '0)
                     && (counter == compare_p_value);
   assign out_lvl  = output_initial_state ^ output_polarity;

   ////////////////////////////////////////////////////////////////////////////
   // Timer tick divider
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         div_cnt <= 16'h0000;
         tick    <= 1'b0;
      end else if (div_cnt == 16'(TICK_DIV - 1)) begin
         div_cnt <= 16'h0000;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
         tick    <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         timer_mode_sel        <= 2'h0;
         pin_function          <= 2'h0;
         output_initial_state  <= 1'b0;
         output_polarity       <= 1'b0;
         capture_source_select <= 1'b0;
         counter_clear_select  <= 1'b0;
      end else if (wr_i && addr_i == PTS_A_CTRL1) begin
         timer_mode_sel        <= wdata_i[PTS_B_MODE +: 2];
         pin_function          <= wdata_i[PTS_B_PINF +: 2];
         output_initial_state  <= wdata_i[PTS_B_OC];
         output_polarity       <= wdata_i[PTS_B_POL];
         capture_source_select <= wdata_i[PTS_B_CAPTS];
         counter_clear_select  <= wdata_i[PTS_B_CCLR];
      end
   end

   // Run bit: trigger edge and software set; match clear; set wins
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         run_bit <= 1'b0;
         run_q   <= 1'b0;
      end else begin
         run_q <= run_bit;
         if (trg_edge)
            run_bit <= 1'b1;
         else if (wr_i && addr_i == PTS_A_CTRL0)
            run_bit <= wdata_i[PTS_B_RUN];
         else if (a_match)
            run_bit <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Run state
   always_comb begin
      next_state = state;
      case (state)
         PTS_ST_IDLE: begin
            if (run_rise && sp_mode)
               next_state = PTS_ST_RUN;
            else if (run_rise && cap_mode)
               next_state = PTS_ST_CAP;
         end
         PTS_ST_RUN: if (!run_bit || !sp_mode) next_state = PTS_ST_IDLE;
         PTS_ST_CAP: if (!run_bit || !cap_mode) next_state = PTS_ST_IDLE;
         default:    next_state = PTS_ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i)
         state <= PTS_ST_IDLE;
      else
         state <= next_state;
   end

   // Counter
   always_ff @(posedge mclk_i) begin
      if (!resetn_i)
         counter <= '0;
      else if (run_rise && (sp_mode || cap_mode))
         counter <= '0;
      else if (p_match)
         counter <= '0;
      else if (tick && state == PTS_ST_CAP)
         counter <= counter + 16'h0001;
      else if (tick && state == PTS_ST_RUN && !a_match)
         counter <= counter + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture: edge registered one clock, load next; flag one clock after load
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         cap_pend <= 1'b0;
         af_pend  <= 1'b0;
      end else begin
         cap_pend <= cap_edge;
         af_pend  <= cap_pend;
      end
   end

   // Compare A value: software bytes or capture; capture wins
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         compare_a_value <= '0;
         a_hi_buf        <= PTS_RST_BYTE;
      end else if (cap_pend) begin
         compare_a_value <= counter;
      end else if (wr_i && addr_i == PTS_A_CCRAL) begin
         compare_a_value <= {a_hi_buf, wdata_i};
      end else if (wr_i && addr_i == PTS_A_CCRAH) begin
         a_hi_buf        <= wdata_i;
         compare_a_value <= {wdata_i, compare_a_value[7:0]};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         compare_p_value <= '0;
         p_hi_buf        <= PTS_RST_BYTE;
      end else if (wr_i && addr_i == PTS_A_CCRPL) begin
         compare_p_value <= {p_hi_buf, wdata_i};
      end else if (wr_i && addr_i == PTS_A_CCRPH) begin
         p_hi_buf        <= wdata_i;
         compare_p_value <= {wdata_i, compare_p_value[7:0]};
      end
   end

   // Flags: hardware set wins over write-1 clear
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         compare_a_flag_o <= 1'b0;
         compare_p_flag_o <= 1'b0;
      end else begin
         if (a_match || af_pend)
            compare_a_flag_o <= 1'b1;
         else if (wr_i && addr_i == PTS_A_CTRL0 && wdata_i[PTS_B_AF])
            compare_a_flag_o <= 1'b0;
         if (p_match)
            compare_p_flag_o <= 1'b1;
         else if (wr_i && addr_i == PTS_A_CTRL0 && wdata_i[PTS_B_PF])
            compare_p_flag_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pin: low outside single pulse; there initial state XOR polarity when idle, inverted level while pulsing
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         timer_out_o    <= 1'b0;
         timer_out_en_o <= 1'b0;
      end else begin
         timer_out_en_o <= sp_mode;
         if (!sp_mode)
            timer_out_o <= 1'b0;
         else if (next_state == PTS_ST_RUN)
            timer_out_o <= ~out_lvl;
         else
            timer_out_o <= out_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port, data in the cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      case (addr_i)
         PTS_A_CTRL0: next_rdata = {4'h0, run_bit, 1'b0, compare_p_flag_o, compare_a_flag_o};
         PTS_A_CTRL1: next_rdata = {timer_mode_sel, pin_function, output_initial_state,
                                    output_polarity, capture_source_select,
                                    counter_clear_select};
         PTS_A_CNTL:  next_rdata = counter[7:0];
         PTS_A_CNTH:  next_rdata = counter[15:8];
         PTS_A_CCRAL: next_rdata = compare_a_value[7:0];
         PTS_A_CCRAH: next_rdata = compare_a_value[15:8];
         PTS_A_CCRPL: next_rdata = compare_p_value[7:0];
         PTS_A_CCRPH: next_rdata = compare_p_value[15:8];
         default:     next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!resetn_i)
         rdata_o <= 8'h00;
      else if (rd_i)
         rdata_o <= next_rdata;
      else
         rdata_o <= 8'h00;
   end
endmodule

// *** logic/pts_pkg.sv ***
// Purpose: Constants for the periodic timer single-pulse and capture block
// Assumes: 8-bit register port, 200 MHz mclk_i, timer tick enable from a divider
// Notes:   Byte-wide registers; 16-bit values read and written as low/high bytes
//
// Operation
// - Run bit rising in single pulse starts counter and drives pulse leading edge.
// - Trigger pin active edge sets run bit in single pulse mode.
// - Clearing run or compare A match ends pulse; match clears run bit.
// - Compare A match in single pulse raises compare A flag.
// - In single pulse, counter clears only when run bit rises.
// - Single pulse ignores compare P value and counter clear select.
// - Capture source select picks capture pin or trigger pin.
// - Pin function picks rising, falling or both edges; 11 captures nothing.
// - Capture mode counter free-runs until run bit falls.
// - Active capture edge copies counter into compare A and raises flag.
// - Compare P match in capture clears counter and raises compare P flag.
// - Compare P of zero lets counter run its full range.
// - Capture pulses shorter than two timer ticks may be ignored.
// - Compare A flag set one clock (a quarter tick) after capture load.
// - Capture edge to compare A load latency under 1.5 ticks.
// - Capture mode ignores clear select, initial state, polarity; no output.
// - Counter, compare A and compare P are 16 bits, accessed as bytes.
// - Run bit rising in single pulse sets output to the inverse of the idle level.
package pts_pkg;
   localparam int          PTS_CNT_W      = 16;
   localparam logic [2:0]  PTS_A_CTRL0    = 3'h0;
   localparam logic [2:0]  PTS_A_CTRL1    = 3'h1;
   localparam logic [2:0]  PTS_A_CNTL     = 3'h2;
   localparam logic [2:0]  PTS_A_CNTH     = 3'h3;
   localparam logic [2:0]  PTS_A_CCRAL    = 3'h4;
   localparam logic [2:0]  PTS_A_CCRAH    = 3'h5;
   localparam logic [2:0]  PTS_A_CCRPL    = 3'h6;
   localparam logic [2:0]  PTS_A_CCRPH    = 3'h7;
   // Control 0 fields
   localparam int          PTS_B_RUN      = 3;
   // Control 1 fields
   localparam int          PTS_B_MODE     = 6;
   localparam int          PTS_B_PINF     = 4;
   localparam int          PTS_B_OC       = 3;
   localparam int          PTS_B_POL      = 2;
   localparam int          PTS_B_CAPTS    = 1;
   localparam int          PTS_B_CCLR     = 0;
   // Control 0 flag bits, write 1 to clear
   localparam int          PTS_B_AF       = 0;
   localparam int          PTS_B_PF       = 1;
   localparam logic [1:0]  PTS_MODE_CAP   = 2'h1;
   localparam logic [1:0]  PTS_MODE_SP    = 2'h2;
   localparam logic [1:0]  PTS_PINF_RISE  = 2'h0;
   localparam logic [1:0]  PTS_PINF_FALL  = 2'h1;
   localparam logic [1:0]  PTS_PINF_BOTH  = 2'h2;
   localparam logic [7:0]  PTS_RST_BYTE   = 8'h00;
   localparam int          PTS_TICK_DIV   = 4;
   typedef enum logic [1:0] {
      PTS_ST_IDLE = 2'b00,
      PTS_ST_RUN  = 2'b01,
      PTS_ST_CAP  = 2'b10
   } pts_state_e;
endpackage

// *** logic/pts_edge_sync.sv ***
// Purpose: Two-stage synchroniser with rise and fall detection
// Assumes: Input asynchronous to mclk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pts_edge_sync (
   input  wire logic mclk_i,
   input  wire logic resetn_i,
   input  wire logic pin_i,
   output logic      rise_o,
   output logic      fall_o
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
      end
   end
   assign rise_o = s2 & ~s3;
   assign fall_o = ~s2 & s3;
endmodule

// *** verif/pts_timer_assertions.sv ***
// Purpose: Port properties of the timer
// Assumes: Mirrors follow register writes only
// Notes:   Mirrors miss hardware run changes; guards allow it
`timescale 1ns/1ps
module pts_timer_assertions
   import pts_pkg::*;
#(
   parameter int TICK_DIV = PTS_TICK_DIV
) (
   input wire logic       mclk_i,
   input wire logic       resetn_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic       capture_input_pin_i,
   input wire logic [7:0] rdata_o,
   input wire logic       timer_out_o,
   input wire logic       timer_out_en_o,
   input wire logic       compare_a_flag_o,
   input wire logic       compare_p_flag_o
);
   logic [7:0] c1;
   logic       run_q;
   logic [3:0] a1;
   logic [3:0] a0;
   logic       w0;
   logic       sp;
   logic       cap;
   logic       act;
   assign w0  = wr_i && addr_i == PTS_A_CTRL0;
   assign sp  = c1[7:6] == PTS_MODE_SP;
   assign cap = c1[7:6] == PTS_MODE_CAP;
   // Pulse level is the inverse of the idle level
   assign act = timer_out_o != (c1[PTS_B_OC] ^ c1[PTS_B_POL]);
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         c1 <= PTS_RST_BYTE;
         a1 <= 4'h0;
      end else if (wr_i && addr_i == PTS_A_CTRL1) begin
         c1 <= wdata_i;
         a1 <= 4'h0;
      end else if (a1 != 4'hf) begin
         a1 <= a1 + 4'h1;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         run_q <= 1'b0;
         a0    <= 4'h0;
      end else if (w0) begin
         run_q <= wdata_i[PTS_B_RUN];
         a0    <= 4'h0;
      end else if (a0 != 4'hf) begin
         a0 <= a0 + 4'h1;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////
   property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
   property p_en; a1 == 4'hf |-> timer_out_en_o == sp; endproperty
   a_en: assert property (p_en) else $error("output enable wrong");
   property p_af; compare_a_flag_o && !(w0 && wdata_i[PTS_B_AF]) |=> compare_a_flag_o;
   endproperty
   a_af: assert property (p_af) else $error("A flag lost");
   property p_pf; compare_p_flag_o && !(w0 && wdata_i[PTS_B_PF]) |=> compare_p_flag_o;
   endproperty
   a_pf: assert property (p_pf) else $error("P flag lost");
   property p_cap; a1 == 4'hf && cap && run_q && c1[5:4] == PTS_PINF_RISE
      && !c1[PTS_B_CAPTS] && $rose(capture_input_pin_i) |-> ##[2:8] compare_a_flag_o;
   endproperty
   a_cap: assert property (p_cap) else $error("capture late");
   property p_nocap; a1 == 4'hf && cap && c1[5:4] == 2'h3 |-> !$rose(compare_a_flag_o);
   endproperty
   a_nocap: assert property (p_nocap) else $error("capture in off mode");
   property p_start; sp && !run_q && w0 && wdata_i[PTS_B_RUN] |-> ##[1:3] act; endproperty
   a_start: assert property (p_start) else $error("pulse not started");
   property p_end; a1 == 4'hf && sp && a0 > 4'h4 && $fell(act) |-> compare_a_flag_o;
   endproperty
   a_end: assert property (p_end) else $error("pulse end without A");
endmodule
bind pts_timer pts_timer_assertions #(.TICK_DIV(TICK_DIV)) pts_timer_assertions_i (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .capture_input_pin_i(capture_input_pin_i),
   .rdata_o(rdata_o), .timer_out_o(timer_out_o), .timer_out_en_o(timer_out_en_o),
   .compare_a_flag_o(compare_a_flag_o), .compare_p_flag_o(compare_p_flag_o));

// *** verif/pts_pin_model.sv ***
// Purpose: Far-side driver of trigger and capture pins
// Assumes: Bench asks for levels
// Notes:   Each level holds at least MIN_HOLD + 1 clocks
`timescale 1ns/1ps
module pts_pin_model #(
   parameter int MIN_HOLD = 8
) (
   input  wire logic mclk_i,
   input  wire logic trig_req_i,
   input  wire logic cap_req_i,
   output logic      trig_o = 1'b0,
   output logic      cap_o = 1'b0
);
   int ta = 0;
   int ca = 0;
   // Short pulses may be dropped, so none are sent
   always @(posedge mclk_i) begin
      ta <= ta + 1;
      ca <= ca + 1;
      if (ta >= MIN_HOLD && trig_req_i != trig_o) begin
         trig_o <= trig_req_i;
         ta     <= 0;
      end
      if (ca >= MIN_HOLD && cap_req_i != cap_o) begin
         cap_o <= cap_req_i;
         ca    <= 0;
      end
   end
endmodule

// *** verif/pts_timer_tb_top.sv ***
// Purpose: Self-checking bench of the timer
// Assumes: TICK_DIV of 1, one tick a clock
// Notes:   Read notes queued, popped by monitor
`timescale 1ns/1ps
module pts_timer_tb_top
   import pts_pkg::*;
;
   logic        mclk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic [2:0]  addr_i = 3'h0;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        rd_d = 1'b0;
   logic        trq = 1'b0;
   logic        crq = 1'b0;
   logic        tp;
   logic        cp;
   logic [7:0]  rdata_o;
   logic        tout;
   logic        ten;
   logic        af;
   logic        pfl;
   logic [7:0]  last;
   logic [15:0] q[$];
   logic [15:0] nt;
   logic [7:0]  rnd = 8'h54;
   int          bad_count = 0;
   int          n_checks = 0;
   int          w;
   always #2.5 mclk_i = ~mclk_i;
   pts_timer #(.TICK_DIV(1)) pts_timer_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .ext_timer_clock_pin_i(tp), .capture_input_pin_i(cp), .rdata_o(rdata_o),
      .timer_out_o(tout), .timer_out_en_o(ten), .compare_a_flag_o(af),
      .compare_p_flag_o(pfl));
   pts_pin_model pts_pin_model_i (.mclk_i(mclk_i), .trig_req_i(trq), .cap_req_i(crq),
      .trig_o(tp), .cap_o(cp));
   ////////////////////////////////////////////////////////////
   function automatic logic [7:0] lf(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic bit_chk(input string n, input logic e, input logic g);
      chk(n, {7'h0, e}, {7'h0, g});
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic w16(input logic [2:0] a, input logic [15:0] d);
      wr(a + 3'h1, d[15:8]);
      wr(a, d[7:0]);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      q.push_back({m, e});
      @(posedge mclk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(posedge mclk_i);
      #1;
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic pin(input logic t, input logic l);
      @(posedge mclk_i);
      if (t) trq <= l;
      else crq <= l;
      waitc(20);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge mclk_i) begin
      rd_d <= rd_i;
      if (rd_d) begin
         nt = q.pop_front();
         last = rdata_o;
         chk("rdata", nt[7:0] & nt[15:8], rdata_o & nt[15:8]);
      end
   end
   initial begin
      waitc(4);
      resetn_i <= 1'b1;
      for (int i = 0; i < 8; i++) rd(3'(i), PTS_RST_BYTE, 8'hff);
      rnd = lf(rnd);
      w16(PTS_A_CCRPL, {rnd, ~rnd});
      rd(PTS_A_CCRPL, ~rnd, 8'hff);
      rd(PTS_A_CCRPH, rnd, 8'hff);
      // Small P and clear select must not cut the pulse
      w16(PTS_A_CCRPL, 16'h0003);
      w = 8 + int'(rnd[4:0]);
      w16(PTS_A_CCRAL, 16'(w));
      wr(PTS_A_CTRL1, 8'hb1);
      wr(PTS_A_CTRL0, 8'h08);
      waitc(3);
      bit_chk("lead", 1'b1, tout);
      bit_chk("en", 1'b1, ten);
      waitc(w - 6);
      bit_chk("width", 1'b1, tout);
      waitc(18);
      bit_chk("trail", 1'b0, tout);
      bit_chk("aflag", 1'b1, af);
      rd(PTS_A_CTRL0, 8'h01, 8'h0b);
      rd(PTS_A_CNTL, 8'h00, 8'h00);
      bit_chk("stop", 1'b1, last >= 8'(w) && last <= 8'(w + 1));
      wr(PTS_A_CTRL0, 8'h09);
      rd(PTS_A_CNTL, 8'h00, 8'h00);
      bit_chk("restart", 1'b1, last < 8'h08);
      waitc(w + 10);
      w16(PTS_A_CCRAL, 16'h0100);
      wr(PTS_A_CTRL1, 8'hb8);
      wr(PTS_A_CTRL0, 8'h03);
      waitc(4);
      bit_chk("idle", 1'b1, tout);
      pin(1'b1, 1'b1);
      bit_chk("trig", 1'b0, tout);
      rd(PTS_A_CTRL0, 8'h08, 8'h0b);
      wr(PTS_A_CTRL0, 8'h00);
      waitc(4);
      bit_chk("swclr", 1'b1, tout);
      pin(1'b1, 1'b0);
      for (int pf = 0; pf < 4; pf++) begin
         for (int s = 0; s < 2; s++) begin
            wr(PTS_A_CTRL0, 8'h03);
            w16(PTS_A_CCRAL, 16'h0000);
            w16(PTS_A_CCRPL, 16'h0000);
            wr(PTS_A_CTRL1, {PTS_MODE_CAP, 2'(pf), 2'h3, 1'(s), 1'b1});
            wr(PTS_A_CTRL0, 8'h08);
            pin(s == 0, 1'b1);
            rd(PTS_A_CTRL0, 8'h08, 8'h0b);
            pin(s == 1, 1'b1);
            rd(PTS_A_CTRL0, {7'h04, pf == 0 || pf == 2}, 8'h0b);
            rd(PTS_A_CCRAL, 8'h00, 8'h00);
            bit_chk("cap", pf == 0 || pf == 2, last != 8'h00);
            bit_chk("en_cap", 1'b0, ten);
            wr(PTS_A_CTRL0, 8'h0b);
            pin(s == 1, 1'b0);
            rd(PTS_A_CTRL0, {7'h04, pf == 1 || pf == 2}, 8'h0b);
            pin(s == 0, 1'b0);
         end
      end
      w16(PTS_A_CCRPL, 16'h0010);
      wr(PTS_A_CTRL0, 8'h03);
      wr(PTS_A_CTRL0, 8'h08);
      waitc(100);
      rd(PTS_A_CTRL0, 8'h0a, 8'h0b);
      rd(PTS_A_CNTL, 8'h00, 8'h00);
      bit_chk("wrap", 1'b1, last <= 8'h10);
      bit_chk("pflag", 1'b1, pfl);
      // Stop first so a late P match cannot beat the flag clear
      wr(PTS_A_CTRL0, 8'h00);
      w16(PTS_A_CCRPL, 16'h0000);
      wr(PTS_A_CTRL0, 8'h03);
      wr(PTS_A_CTRL0, 8'h08);
      waitc(300);
      rd(PTS_A_CTRL0, 8'h08, 8'h0b);
      rd(PTS_A_CNTH, 8'h00, 8'h00);
      bit_chk("full", 1'b1, last != 8'h00);
      summarize();
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      summarize();
   end
endmodule
